// ### design/bplc_top.sv
/*
  burst power loop control: start detection, slow-start and init timing,
  bias search and tracking, output gating, fault flag and register port.
  assumes synchronous inputs, a comparator flag for monitor vs target,
  and a digital code for the resistor-set ceiling.
*/
`timescale 1ns/1ns
`include "bplc_cfg.svh"
module bplc_top
  import bplc_pkg::*;
#(
  parameter int BIAS_W = 8,
  parameter int UPDATE_CYC = 4,
  parameter int MIN_ON_CYC = 6
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // chip control
  input wire logic chip_en_n_in,
  input wire logic supply_ok_in,
  input wire logic long_burst_sel_in,
  input wire bplc_burst_type burst_gate_in,
  // sense and settings
  input wire logic monitor_above_in,
  input wire logic [BIAS_W-1:0] bias_ceiling_set_in,
  input wire logic bias_ceiling_short_in,
  input wire logic modulation_level_short_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // laser drive
  output logic bias_en_out,
  output logic mod_en_out,
  output logic [BIAS_W-1:0] bias_code_out,
  output logic loop_fault_n_out
);
  localparam logic [7:0] SLOW_LAST = 8'(`BPLC_CYC_UP(`BPLC_SLOW_NS) - 1);
  localparam logic [7:0] EN_LAST = 8'(`BPLC_CYC_UP(`BPLC_INIT_EN_NS) - 1);
  localparam logic [7:0] LONG_LAST = 8'(`BPLC_CYC_UP(`BPLC_INIT_LONG_NS) - 1);
  localparam logic [7:0] PWR_LAST = 8'(`BPLC_CYC_UP(`BPLC_INIT_PWR_NS) - 1);
  localparam logic [7:0] BURST_LAST = 8'(`BPLC_CYC_UP(`BPLC_INIT_BURST_NS) - 1);
  localparam logic [7:0] TICK_LAST = 8'(UPDATE_CYC - 1);
  localparam logic [7:0] MIN_ON = 8'(MIN_ON_CYC);

  ////////////////////////////////////////////////////////////////////////
  // state
  bplc_state_type state;
  bplc_state_type next_state;
  logic cause_pwr;
  logic burst_wait;
  logic [7:0] init_last;
  logic burst_prev;
  logic [7:0] on_cnt;
  logic [1:0] burst_cnt;
  logic stuck;
  logic open_loop;
  logic [7:0] init_count;
  logic init_expired;
  logic tick;
  logic [BIAS_W-1:0] code;
  logic at_ceiling;
  logic at_floor;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire logic dis = chip_en_n_in || !supply_ok_in;
  wire logic burst_true = burst_gate_in.pos && !burst_gate_in.neg;
  wire logic shorted = bias_ceiling_short_in || modulation_level_short_in;
  wire logic st_off = (state == BPLC_OFF);
  wire logic st_wait = (state == BPLC_WAIT);
  wire logic st_slow = (state == BPLC_SLOW);
  wire logic st_search = (state == BPLC_SEARCH);
  wire logic st_fine = (state == BPLC_FINE);
  wire logic in_init = st_slow || st_search;
  wire logic burst_fall = burst_prev && !burst_true;
  wire logic compliant = burst_fall && (on_cnt >= MIN_ON);
  wire logic bursts_done = (burst_cnt == `BPLC_INIT_BURSTS);
  wire logic slow_done = st_slow && (init_count == SLOW_LAST);
  wire logic init_done = st_search && (init_expired || bursts_done);
  wire logic [7:0] start_last = burst_wait ? BURST_LAST :
                                cause_pwr ? PWR_LAST :
                                long_burst_sel_in ? LONG_LAST : EN_LAST;
  wire logic update = tick && (st_search || st_fine);
  wire logic need_up = !monitor_above_in;
  wire logic next_stuck = (need_up && at_ceiling) || (!need_up && at_floor);
  wire logic drive_on = !dis && burst_true && !shorted && (st_search || st_fine);
  wire logic [BIAS_W-1:0] clamped = (code > bias_ceiling_set_in) ? bias_ceiling_set_in : code;
  wire logic [BIAS_W-1:0] next_bias = open_loop ? bias_ceiling_set_in : clamped;
  wire bplc_status_type status = '{bursts: burst_cnt, cause_pwr: cause_pwr,
                                   burst_wait: burst_wait, fine: st_fine, init: in_init,
                                   fault: !loop_fault_n_out, state: state};
  wire logic [31:0] bias_word = (32'(bias_ceiling_set_in) << `BPLC_BIAS_CEIL_LSB) | 32'(code);
  wire logic [31:0] next_rdata = !reg_rd_in ? 32'h0000_0000 :
                                 (reg_addr_in == `BPLC_REG_CTRL) ? 32'(open_loop) :
                                 (reg_addr_in == `BPLC_REG_STATUS) ? 32'(status) :
                                 (reg_addr_in == `BPLC_REG_BIAS) ? bias_word : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      BPLC_OFF: next_state = BPLC_WAIT;
      BPLC_WAIT:
        if (burst_true)
          next_state = BPLC_SLOW;
      BPLC_SLOW:
        if (slow_done)
          next_state = BPLC_SEARCH;
      BPLC_SEARCH:
        if (init_done)
          next_state = BPLC_FINE;
      BPLC_FINE: next_state = BPLC_FINE;
      default: next_state = BPLC_OFF;
    endcase
    if (dis)
      next_state = BPLC_OFF;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state <= BPLC_OFF;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cause_pwr <= 1'b1;
      burst_wait <= 1'b0;
      init_last <= '0;
    end
    else if (st_off)
    begin
      // reset or a supply drop marks power-up; only an enable toggle with supply up clears it
      if (!supply_ok_in)
        cause_pwr <= 1'b1;
      else if (chip_en_n_in)
        cause_pwr <= 1'b0;
      burst_wait <= 1'b0;
    end
    else if (st_wait)
    begin
      if (!burst_true)
        burst_wait <= 1'b1;
      init_last <= start_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst counting
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      burst_prev <= 1'b0;
      on_cnt <= '0;
      burst_cnt <= '0;
    end
    else
    begin
      burst_prev <= burst_true;
      on_cnt <= !burst_true ? 8'h00 : (on_cnt == 8'hff) ? on_cnt : on_cnt + 8'h01;
      if (!in_init)
        burst_cnt <= '0;
      else if (compliant && !bursts_done)
        burst_cnt <= burst_cnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timers and bias search
  bplc_timer #(.W(8)) u_init_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(!in_init),
    .run_in(in_init),
    .limit_in(init_last),
    .count_out(init_count),
    .expired_out(init_expired)
  );

  bplc_timer #(.W(8)) u_tick_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(!burst_true),
    .run_in(burst_true && (st_search || st_fine)),
    .limit_in(TICK_LAST),
    .count_out(),
    .expired_out(tick)
  );

  bplc_search #(.W(BIAS_W)) u_search (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(st_off || st_wait),
    .update_in(update),
    .fine_in(st_fine),
    .lower_in(monitor_above_in),
    .ceiling_in(bias_ceiling_set_in),
    .code_out(code),
    .at_ceiling_out(at_ceiling),
    .at_floor_out(at_floor)
  );

  ////////////////////////////////////////////////////////////////////////
  // fault and drive
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      stuck <= 1'b0;
    else if (!st_fine)
      stuck <= 1'b0;
    else if (update)
      stuck <= next_stuck;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      loop_fault_n_out <= 1'b1;
      bias_en_out <= 1'b0;
      mod_en_out <= 1'b0;
      bias_code_out <= '0;
    end
    else
    begin
      loop_fault_n_out <= !(in_init || stuck);
      bias_en_out <= drive_on;
      mod_en_out <= drive_on;
      bias_code_out <= dis ? '0 : next_bias;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      open_loop <= `BPLC_CTRL_RST;
      reg_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr_in && (reg_addr_in == `BPLC_REG_CTRL))
        open_loop <= reg_wdata_in[`BPLC_CTRL_OPEN_BIT];
      reg_rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_in); endclocking

  sequence slow_phase;
    st_slow [*5] ##1 st_search;
  endsequence

  sequence fine_update_up_at_ceiling;
    st_fine && update && need_up && at_ceiling;
  endsequence

  AST_FAULT_IN_INIT: assert property (disable iff (!rst_n_in) in_init |=> !loop_fault_n_out)
    else $error("fault flag high during initialization");
  AST_SLOW_START: assert property (disable iff (!rst_n_in || dis)
    $rose(st_slow) |-> slow_phase)
    else $error("slow-start length wrong");
  AST_DISABLE_OFF: assert property (disable iff (!rst_n_in)
    dis |=> st_off && !bias_en_out && !mod_en_out && (bias_code_out == '0))
    else $error("outputs not off while disabled");
  AST_BURST_START: assert property (disable iff (!rst_n_in || dis)
    st_wait && burst_true && burst_wait |=> st_slow && (init_last == BURST_LAST))
    else $error("burst start duration wrong");
  AST_PWR_START: assert property (disable iff (!rst_n_in || dis)
    st_wait && burst_true && !burst_wait && cause_pwr |=> (init_last == PWR_LAST))
    else $error("power-up duration wrong");
  AST_INIT_BOUND: assert property (disable iff (!rst_n_in || dis)
    $rose(st_search) |-> ##[1:120] st_fine)
    else $error("initialization not finished in time");
  AST_THREE_BURSTS: assert property (disable iff (!rst_n_in || dis)
    st_search && bursts_done |=> st_fine)
    else $error("three bursts did not end initialization");
  AST_FOLLOW_GATE: assert property (disable iff (!rst_n_in || dis)
    st_fine && !shorted |=> (bias_en_out == $past(burst_true)) && (mod_en_out == bias_en_out))
    else $error("drive does not follow burst gate");
  AST_SHORT_OFF: assert property (disable iff (!rst_n_in) shorted |=> !bias_en_out && !mod_en_out)
    else $error("drive on with setting pin shorted");
  AST_CEILING: assert property (disable iff (!rst_n_in) bias_code_out <= $past(bias_ceiling_set_in))
    else $error("bias above ceiling");
  AST_HOLD: assert property (disable iff (!rst_n_in || dis)
    st_fine && !burst_true |=> $stable(code))
    else $error("bias code moved while burst low");
  AST_FINE_STEP: assert property (disable iff (!rst_n_in || dis)
    st_fine && update |=> (code == $past(code) + BIAS_W'(1)) || (code == $past(code) - BIAS_W'(1))
      || (code == $past(code)))
    else $error("fine step larger than one");
  AST_FAULT_CEIL: assert property (disable iff (!rst_n_in || dis)
    fine_update_up_at_ceiling |-> ##2 !loop_fault_n_out)
    else $error("no fault at ceiling");
  AST_FAULT_FLOOR: assert property (disable iff (!rst_n_in || dis)
    st_fine && update && monitor_above_in && at_floor |-> ##2 !loop_fault_n_out)
    else $error("no fault at floor");
endmodule

// ### design/bplc_cfg.svh
/*
  constants of the burst power loop control: timing, register map, field positions.
  assumes a 10 MHz system clock; included by bare name.
*/
`ifndef BPLC_CFG_SVH
`define BPLC_CFG_SVH
// Behaviour
// - fault low when loop cannot hold target
// - bias clamped at ceiling, fault asserted
// - fault when bias cannot go lower
// - fault low throughout initialization
// - slow-start delay 450ns opens initialization
// - chip disabled: outputs off, loop reset
// - enable release starts init, 2.1/3.72us
// - init coarse search, then fine tracking
// - power-up continuous start takes 12us
// - first burst after reset starts 1.6us init
// - bursting or continuous never restarts init
// - init ends after three bursts or timeout
// - after init outputs follow burst gate
// - setting pin short turns outputs off
// - loop never raises bias above ceiling
// - burst low holds stored bias code
// - burst high adjusts bias code
// - startup pseudo-binary search against reference

`define BPLC_CLK_NS 100
`define BPLC_SLOW_NS 450
`define BPLC_INIT_EN_NS 2100
`define BPLC_INIT_LONG_NS 3720
`define BPLC_INIT_PWR_NS 12000
`define BPLC_INIT_BURST_NS 1600
`define BPLC_CYC_UP(ns) (((ns) + `BPLC_CLK_NS - 1) / `BPLC_CLK_NS)
`define BPLC_INIT_BURSTS 2'h3

`define BPLC_REG_CTRL 4'h0
`define BPLC_REG_STATUS 4'h4
`define BPLC_REG_BIAS 4'h8
`define BPLC_CTRL_OPEN_BIT 0
`define BPLC_CTRL_RST 1'h0
`define BPLC_BIAS_CEIL_LSB 16
`endif

// ### design/bplc_pkg.sv
/*
  types of the burst power loop control.
  assumes bplc_cfg.svh for the numeric constants.
*/
package bplc_pkg;
  typedef enum logic [2:0] {
    BPLC_OFF = 3'b000,
    BPLC_WAIT = 3'b001,
    BPLC_SLOW = 3'b010,
    BPLC_SEARCH = 3'b011,
    BPLC_FINE = 3'b100
  } bplc_state_type;

  typedef struct packed {
    logic pos;
    logic neg;
  } bplc_burst_type;

  typedef struct packed {
    logic [1:0] bursts;
    logic cause_pwr;
    logic burst_wait;
    logic fine;
    logic init;
    logic fault;
    bplc_state_type state;
  } bplc_status_type;
endpackage

// ### design/bplc_timer.sv
/*
  elapsed-cycle counter with clear, run and a terminal pulse.
  assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ns
module bplc_timer
  import bplc_pkg::*;
#(
  parameter int W = 8
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic [W-1:0] limit_in,
  // state
  output logic [W-1:0] count_out,
  output logic expired_out
);
  wire logic at_limit = (count_out == limit_in);

  assign expired_out = run_in && at_limit;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count_out <= '0;
    else if (clear_in || expired_out)
      count_out <= '0;
    else if (run_in)
      count_out <= count_out + W'(1);
  end
endmodule

// ### design/bplc_search.sv
/*
  bias code register: halving-step search, then one-unit tracking.
  assumes updates only while the comparator result is valid.
*/
`timescale 1ns/1ns
module bplc_search
  import bplc_pkg::*;
#(
  parameter int W = 8
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic clear_in,
  input wire logic update_in,
  input wire logic fine_in,
  input wire logic lower_in,
  input wire logic [W-1:0] ceiling_in,
  // state
  output logic [W-1:0] code_out,
  output logic at_ceiling_out,
  output logic at_floor_out
);
  logic [W-1:0] step;
  wire logic [W-1:0] use_step = fine_in ? W'(1) : step;
  wire logic [W:0] up_sum = {1'b0, code_out} + {1'b0, use_step};
  wire logic [W-1:0] up_code = (up_sum > {1'b0, ceiling_in}) ? ceiling_in : up_sum[W-1:0];
  wire logic [W-1:0] dn_code = (code_out > use_step) ? code_out - use_step : '0;
  wire logic [W-1:0] next_code = lower_in ? dn_code : up_code;
  wire logic [W-1:0] next_step = (step > W'(1)) ? (step >> 1) : W'(1);

  assign at_ceiling_out = (code_out >= ceiling_in);
  assign at_floor_out = (code_out == '0);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      code_out <= '0;
      step <= W'(1) << (W - 1);
    end
    else if (clear_in)
    begin
      code_out <= '0;
      step <= W'(1) << (W - 1);
    end
    else if (update_in)
    begin
      code_out <= next_code;
      step <= next_step;
    end
  end
endmodule

// ### verif/bplc_laser_model.sv
/*
  laser diode with its monitor photodiode and the power comparator.
  assumes the bias code rises with optical power; target_in is the code
  at which monitor current matches the reference.
*/
`timescale 1ns/1ns
module bplc_laser_model (
  // clock
  input wire logic clk_in,
  // drive from the block
  input wire logic bias_en_in,
  input wire logic [7:0] bias_code_in,
  // laser condition
  input wire logic [7:0] target_in,
  input wire logic cathode_short_in,
  // comparator
  output logic monitor_above_out
);
  ////////////////////////////////////////////////////////////////
  // a shorted cathode lights the laser whatever the bias; dark laser gives no current
  always_ff @(posedge clk_in)
  begin
    if (cathode_short_in)
      monitor_above_out <= 1'h1;
    else if (bias_en_in)
      monitor_above_out <= (bias_code_in > target_in);
    else
      monitor_above_out <= 1'h0;
  end
endmodule

// ### verif/burst_power_loop_control_tb.sv
/*
  self-checking bench of the burst power loop control.
  assumes bplc_top with its default widths and a laser model on the far side.
*/
`timescale 1ns/1ns
module burst_power_loop_control_tb
  import bplc_pkg::*;
;
  logic clk = 1'h0, rst_n = 1'h0, en_n = 1'h0, sup = 1'h0, lng = 1'h0;
  logic sc_b = 1'h0, sc_m = 1'h0, rd = 1'h0, wr = 1'h0, cath = 1'h0, mon;
  logic bias_en, mod_en, fault_n, pb, ppb;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [7:0] ceil = 8'hc8, target = 8'h5a, code, pc;
  logic [1:0] offv [3] = '{2'b00, 2'b01, 2'b11};
  bplc_burst_type burst = 2'b01;
  int fail_count = 0, checked = 0, n, i, len;
  integer seed = 32'h10e4_85fc;

  initial forever #50 clk = ~clk;

  bplc_top #(.BIAS_W(8), .UPDATE_CYC(4), .MIN_ON_CYC(6)) u_dut (
    .clk_in(clk), .rst_n_in(rst_n), .chip_en_n_in(en_n), .supply_ok_in(sup),
    .long_burst_sel_in(lng), .burst_gate_in(burst), .monitor_above_in(mon),
    .bias_ceiling_set_in(ceil), .bias_ceiling_short_in(sc_b),
    .modulation_level_short_in(sc_m), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .bias_en_out(bias_en),
    .mod_en_out(mod_en), .bias_code_out(code), .loop_fault_n_out(fault_n));

  bplc_laser_model u_laser (.clk_in(clk), .bias_en_in(bias_en), .bias_code_in(code),
    .target_in(target), .cathode_short_in(cath), .monitor_above_out(mon));

  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // clock cycles of a typical duration, rounded up to whole clocks
  function automatic int cyc_of(input int ns);
    return (ns + 99) / 100;
  endfunction

  task end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #10 d = rdata;
  endtask

  task wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task wait_fault(input logic lvl, input int lim);
    n = 0;
    while (fault_n !== lvl && n < lim)
    begin
      @(posedge clk);
      #10 n++;
    end
    if (fault_n !== lvl)
    begin
      fail_count++;
      $display("wrong value at %0t: wait ran out", $time);
      end_of_test;
    end
  endtask

  // length of the fault-low window that marks initialization
  task init_len(input int lim);
    wait_fault(1'h0, 60);
    wait_fault(1'h1, 400);
    chk(n >= lim - 1 && n <= lim + 3, 1'h1, "init length");
  endtask

  task restart(input logic l);
    @(posedge clk);
    en_n <= 1'h1;
    lng <= l;
    burst <= 2'b10;
    rd_reg(4'h4);
    chk(d[2:0], 3'h0, "off state");
    chk(bias_en | mod_en, 1'h0, "off drive");
    chk(code, 8'h00, "code reset");
    @(posedge clk);
    en_n <= 1'h0;
  endtask

  task power_up;
    @(posedge clk);
    rst_n <= 1'h0;
    sup <= 1'h0;
    burst <= 2'b10;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    sup <= 1'h1;
    repeat (3) @(posedge clk);
    #10 chk(bias_en, 1'h0, "slow start");
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    sup <= 1'h1;
    @(posedge clk);
    #10 chk(fault_n, 1'h1, "idle fault");
    rd_reg(4'h0);
    chk(d, 32'h0000_0000, "ctrl reset");
    rd_reg(4'h8);
    chk(d[23:16], ceil, "ceiling field");
    rd_reg(4'hc);
    chk(d, 32'h0000_0000, "unmapped");
    wr_reg(4'h4, 32'hffff_ffff);
    rd_reg(4'h4);
    chk({d[6], d[2:0]}, 4'h9, "waiting for burst");
    $display("test registers done");
    @(posedge clk);
    burst <= 2'b10;
    init_len(cyc_of(1600));
    rd_reg(4'h4);
    chk(d[2:0], 3'h4, "fine mode");
    $display("test burst startup done");
    pb = 1'h1;
    for (i = 0; i < 40; i++)
    begin
      len = ((i % 2) ? 2 : 6) + ($random(seed) & 7);
      repeat (len)
      begin
        ppb = pb;
        pb = (burst == 2'b10);
        pc = code;
        @(posedge clk);
        burst <= (i % 2) ? offv[i % 3] : 2'b10;
        #10 chk(bias_en, pb, "gate");
        chk(mod_en, bias_en, "mod gate");
        chk(fault_n, 1'h1, "no fault");
        chk(code <= ceil && (code - pc == 1 || pc - code == 1 || code == pc), 1'h1, "step");
        if (!pb && !ppb)
          chk(code, pc, "hold");
      end
    end
    rd_reg(4'h4);
    chk(d[2:0], 3'h4, "still fine");
    @(posedge clk);
    burst <= 2'b10;
    target <= 8'h78;
    pc = code;
    repeat (60) @(posedge clk);
    #10 chk(code > pc, 1'h1, "tracking");
    $display("test gating done");
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      sc_b <= (i == 0);
      sc_m <= (i == 1);
      repeat (2) @(posedge clk);
      #10 chk(bias_en | mod_en, 1'h0, "short");
    end
    @(posedge clk);
    sc_m <= 1'h0;
    repeat (2) @(posedge clk);
    #10 chk(bias_en, 1'h1, "short gone");
    $display("test shorts done");
    target <= 8'hff;
    wait_fault(1'h0, 900);
    chk(code, ceil, "clamped");
    target <= 8'h5a;
    cath <= 1'h1;
    wait_fault(1'h1, 20);
    wait_fault(1'h0, 1200);
    chk(code, 8'h00, "cannot lower");
    cath <= 1'h0;
    wr_reg(4'h0, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #10 chk(code, ceil, "open loop");
    wr_reg(4'h0, 32'h0000_0000);
    $display("test faults done");
    for (i = 0; i < 2; i++)
    begin
      restart(i[0]);
      init_len(i ? cyc_of(3720) : cyc_of(2100));
    end
    $display("test enable done");
    power_up;
    init_len(cyc_of(12000));
    power_up;
    fork
      begin
        wait_fault(1'h0, 60);
        wait_fault(1'h1, 400);
        chk(n <= 50, 1'h1, "three bursts");
      end
      repeat (5)
      begin
        repeat (8) @(posedge clk);
        burst <= 2'b01;
        repeat (2) @(posedge clk);
        burst <= 2'b10;
      end
    join
    $display("test power-up done");
    end_of_test;
  end
endmodule
